// [rtl/ncc_pkg.sv]
/*
  Constants, types and register map of the numeric coprocessor control
  block: opcodes, control and status word layout, tags, constants and
  the save image layout.
  Assumes a single 20 MHz clock and a synchronous active-high reset.
*/
package ncc_pkg;

  // ==========================================================
  // Register bus
  localparam int NCC_AW = 8;
  localparam int NCC_DW = 32;
  localparam logic [7:0] NCC_REG_CMD = 8'h00;
  localparam logic [7:0] NCC_REG_STATUS = 8'h08;
  localparam logic [7:0] NCC_REG_CONTROL = 8'h0c;
  localparam logic [7:0] NCC_REG_TOP_LO = 8'h10;
  localparam logic [7:0] NCC_REG_TOP_MID = 8'h14;
  localparam logic [7:0] NCC_REG_TOP_HI = 8'h18;
  localparam logic [7:0] NCC_REG_MEM_BASE = 8'h1c;
  localparam logic [7:0] NCC_REG_TAGS = 8'h20;
  localparam int NCC_CMD_NOWAIT_BIT = 8;
  localparam int NCC_MAW = 20;

  // ==========================================================
  // Instruction codes
  typedef enum logic [4:0] {
    OP_Y_TIMES_LOG2_X = 5'h00,
    OP_Y_TIMES_LOG2_X_PLUS_ONE = 5'h01,
    OP_PUSH_ZERO_CONST = 5'h02,
    OP_PUSH_ONE_CONST = 5'h03,
    OP_PUSH_PI_CONST = 5'h04,
    OP_PUSH_LOG2_TEN = 5'h05,
    OP_PUSH_LOG2_E = 5'h06,
    OP_PUSH_LOG10_TWO = 5'h07,
    OP_PUSH_LN_TWO = 5'h08,
    OP_INITIALIZE = 5'h09,
    OP_DISABLE_IRQ = 5'h0a,
    OP_ENABLE_IRQ = 5'h0b,
    OP_LOAD_CONTROL_WORD = 5'h0c,
    OP_STORE_CONTROL_WORD = 5'h0d,
    OP_STORE_STATUS_WORD = 5'h0e,
    OP_CLEAR_EXCEPTIONS = 5'h0f,
    OP_SAVE_STATE = 5'h10,
    OP_RESTORE_STATE = 5'h11
  } ncc_op_t;

  // ==========================================================
  // Temporary real: sign 79, exponent 78:64, significand 63:0
  typedef logic [79:0] ncc_real_t;
  localparam logic [14:0] NCC_EXP_BIAS = 15'h3fff;
  localparam ncc_real_t NCC_K_ZERO = 80'h0;
  localparam ncc_real_t NCC_K_ONE = 80'h3fff_8000000000000000;
  localparam ncc_real_t NCC_K_PI = 80'h4000_c90fdaa22168c235;
  localparam ncc_real_t NCC_K_LOG2_TEN = 80'h4000_d49a784bcd1b8afe;
  localparam ncc_real_t NCC_K_LOG2_E = 80'h3fff_b8aa3b295c17f0bc;
  localparam ncc_real_t NCC_K_LOG10_TWO = 80'h3ffd_9a209a84fbcff799;
  localparam ncc_real_t NCC_K_LN_TWO = 80'h3ffe_b17217f7d1cf79ac;

  // ==========================================================
  // Control and status words
  localparam logic [15:0] NCC_CW_RESET = 16'h03ff;
  localparam int NCC_EXC_W = 6;
  localparam int NCC_CW_IEM_BIT = 7;
  localparam int NCC_EXC_INVALID_BIT = 0;
  localparam int NCC_SW_TOP_LSB = 11;
  localparam int NCC_SW_C3_BIT = 14;
  localparam int NCC_SW_C0_BIT = 8;
  localparam logic [1:0] NCC_TAG_VALID = 2'h0;
  localparam logic [1:0] NCC_TAG_ZERO = 2'h1;
  localparam logic [1:0] NCC_TAG_EMPTY = 2'h3;

  // ==========================================================
  // Save image: 7 environment words, then 8 registers of 5 words
  localparam int NCC_SAVE_BYTES = 94;
  localparam logic [5:0] NCC_SAVE_LAST = 6'(NCC_SAVE_BYTES / 2 - 1);
  localparam logic [5:0] NCC_ENV_WORDS = 6'h07;
  localparam logic [2:0] NCC_PART_LAST = 3'h4;
  localparam logic [5:0] NCC_IDX_CW = 6'h00;
  localparam logic [5:0] NCC_IDX_SW = 6'h01;
  localparam logic [5:0] NCC_IDX_TAG = 6'h02;

  // ==========================================================
  // Sequencing
  localparam logic [5:0] NCC_NEU_CYCLES = 6'h10;
  typedef enum logic [1:0] {X_IDLE = 2'b01, X_BUSY = 2'b10} ncc_xfer_t;
  typedef enum logic [1:0] {N_IDLE = 2'b01, N_RUN = 2'b10} ncc_neu_st_t;

endpackage

// [rtl/ncc_neu_if.sv]
/*
  Link between the control unit and the numeric execution unit.
  Assumes both ends run on the same clock.
*/
interface ncc_neu_if;
  import ncc_pkg::*;
  logic start;
  logic abort;
  logic plus_one;
  ncc_real_t x;
  ncc_real_t y;
  logic busy;
  logic done;
  ncc_real_t result;
  modport ctl (output start, abort, plus_one, x, y,
               input busy, done, result);
  modport neu (input start, abort, plus_one, x, y,
               output busy, done, result);
endinterface

// [rtl/ncc_neu.sv]
/*
  Numeric execution unit for the two logarithm core operations.
  Assumes operands are valid and in range; results outside that are
  undefined. The logarithm is a first-order estimate.
*/
module ncc_neu (
  input wire logic clock,
  input wire logic srst,
  ncc_neu_if.neu nif
);
  import ncc_pkg::*;

  // ==========================================================
  // Arithmetic helpers
  function automatic ncc_real_t ncc_fmul(ncc_real_t a, ncc_real_t b);
    logic [127:0] p;
    logic [16:0] e;
    logic s;
    ncc_real_t r;
    p = a[63:0] * b[63:0];
    e = {2'h0, a[78:64]} + {2'h0, b[78:64]} - {2'h0, NCC_EXP_BIAS};
    s = a[79] ^ b[79];
    if (a[78:64] == 15'h0 || b[78:64] == 15'h0) begin
      r = {s, 79'h0};
    end else if (p[127]) begin
      r = {s, e[14:0] + 15'h1, p[127:64]};
    end else begin
      r = {s, e[14:0], p[126:63]};
    end
    return r;
  endfunction

  function automatic ncc_real_t ncc_fix_to_real(logic [79:0] fx);
    logic [79:0] mag;
    logic [79:0] sh;
    logic [6:0] p;
    ncc_real_t r;
    mag = fx[79] ? 80'(-fx) : fx;
    p = 7'h0;
    for (int i = 0; i < 80; i++) begin
      if (mag[i]) begin
        p = 7'(i);
      end
    end
    sh = mag << (7'h4f - p);
    if (mag == 80'h0) begin
      r = NCC_K_ZERO;
    end else begin
      r = {fx[79], 15'(NCC_EXP_BIAS + {8'h0, p} - 15'h3f), sh[79:16]};
    end
    return r;
  endfunction

  // ==========================================================
  // Combinational result, taken at start
  logic [16:0] x_exp_unb;
  ncc_real_t log_fix;
  ncc_real_t log_val;
  ncc_real_t z_val;
  assign x_exp_unb = {2'h0, nif.x[78:64]} - {2'h0, NCC_EXP_BIAS};
  assign log_fix = ncc_fix_to_real({x_exp_unb, nif.x[62:0]});
  assign log_val = nif.plus_one ? ncc_fmul(nif.x, NCC_K_LOG2_E)
                                : log_fix;
  assign z_val = ncc_fmul(nif.y, log_val);

  // ==========================================================
  // Latency sequencer
  ncc_neu_st_t st_reg;
  logic [5:0] cnt_reg;
  logic done_reg;
  ncc_real_t res_reg;
  logic cnt_end;
  assign cnt_end = cnt_reg == 6'h0;

  always_ff @(posedge clock) begin
    if (srst || nif.abort) begin
      st_reg <= N_IDLE;
      cnt_reg <= 6'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (st_reg)
        N_IDLE: begin
          if (nif.start) begin
            st_reg <= N_RUN;
            cnt_reg <= NCC_NEU_CYCLES;
          end
        end
        N_RUN: begin
          cnt_reg <= cnt_reg - 6'h1;
          if (cnt_end) begin
            st_reg <= N_IDLE;
            done_reg <= 1'b1;
          end
        end
        default: st_reg <= N_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      res_reg <= NCC_K_ZERO;
    end else if (nif.start && st_reg == N_IDLE) begin
      res_reg <= z_val;
    end
  end

  assign nif.busy = st_reg == N_RUN;
  assign nif.done = done_reg;
  assign nif.result = res_reg;

endmodule // ncc_neu

// [rtl/numeric_coproc_control_ops.sv]
/*
  Control unit of the numeric coprocessor: instruction dispatch,
  register stack, control and status words, memory transfers, and
  the interrupt-request and busy pins.
  Assumes a register-bus master on the same clock and a memory slave
  that answers each request with a one-cycle acknowledge.
*/
// Overview of operation
// - Y times log2 X: X from top, Y below, pop, result replaces Y.
// - Y times log2(X+1) takes small X, pops, result replaces Y.
// - Pushed constants carry full 64-bit significands.
// - Constant ops push zero, one, pi, log2 10, log2 e, log10 2, ln 2.
// - No-wait control ops run while busy; only initialize runs during a memory transfer.
// - Initialize equals hardware reset, keeping host fetch sync.
// - No-wait initialize aborts memory cycles in progress.
// - Disable-interrupts sets the mask; no request while it is set.
// - Enable-interrupts clears the mask so requests may be raised.
// - Load control word replaces it; unmasked pending flag raises request.
// - Store status or control writes the word; status store works busy.
// - Clear exceptions clears flags, request and busy; pins go inactive.
// - Save writes environment and stack to a 94-byte area.
// - No-wait save waits for the running numeric operation.
// - After saving, the device initializes itself.
// - Restore reloads the whole state from the 94-byte area.
// - After restore the device acts on the new state at once.
module numeric_coproc_control_ops (
  input wire logic clock,
  input wire logic srst,
  input wire logic [ncc_pkg::NCC_AW-1:0] reg_addr,
  input wire logic [ncc_pkg::NCC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ncc_pkg::NCC_DW-1:0] reg_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [ncc_pkg::NCC_MAW-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic irq,
  output logic busy
);
  import ncc_pkg::*;

  // ==========================================================
  // Decode helpers
  function automatic logic ncc_is_cu_nowait(ncc_op_t op, logic nw);
    return nw && (op == OP_INITIALIZE || op == OP_DISABLE_IRQ ||
      op == OP_ENABLE_IRQ || op == OP_STORE_CONTROL_WORD ||
      op == OP_STORE_STATUS_WORD || op == OP_CLEAR_EXCEPTIONS);
  endfunction

  function automatic logic ncc_can_run(ncc_op_t op, logic nw,
                                       logic nb, logic mb);
    logic cu;
    cu = ncc_is_cu_nowait(op, nw);
    if (cu && op == OP_INITIALIZE) begin
      return 1'b1;
    end
    return !mb && (!nb || cu);
  endfunction

  function automatic ncc_real_t ncc_const(ncc_op_t op);
    case (op)
      OP_PUSH_ONE_CONST: return NCC_K_ONE;
      OP_PUSH_PI_CONST: return NCC_K_PI;
      OP_PUSH_LOG2_TEN: return NCC_K_LOG2_TEN;
      OP_PUSH_LOG2_E: return NCC_K_LOG2_E;
      OP_PUSH_LOG10_TWO: return NCC_K_LOG10_TWO;
      OP_PUSH_LN_TWO: return NCC_K_LN_TWO;
      default: return NCC_K_ZERO;
    endcase
  endfunction

  // ==========================================================
  // State
  ncc_real_t fp_reg [8];
  logic [1:0] tag_reg [8];
  logic [2:0] top_reg;
  logic [15:0] cw_reg;
  logic [NCC_EXC_W-1:0] exc_reg;
  logic [3:0] cc_reg;
  logic busy_reg;
  logic irq_reg;
  logic pend_v_reg;
  ncc_op_t pend_op_reg;
  logic pend_nw_reg;
  logic [NCC_MAW-1:0] base_reg;
  ncc_xfer_t xfer_reg;
  ncc_op_t kind_reg;
  logic [5:0] idx_reg;
  logic [2:0] part_reg;
  logic [2:0] ri_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [NCC_MAW-1:0] mem_addr_reg;
  logic [15:0] mem_wdata_reg;
  logic [NCC_DW-1:0] rdata_reg;

  ncc_neu_if nif ();
  ncc_neu u_neu (
    .clock(clock),
    .srst(srst),
    .nif(nif)
  );

  // ==========================================================
  // Dispatch
  logic cmd_wr;
  ncc_op_t new_op;
  logic new_nw;
  logic mem_busy;
  logic run_pend;
  logic run_new;
  logic store_new;
  logic exe_v;
  ncc_op_t exe_op;
  assign cmd_wr = reg_wr && reg_addr == NCC_REG_CMD;
  assign new_op = ncc_op_t'(reg_wdata[4:0]);
  assign new_nw = reg_wdata[NCC_CMD_NOWAIT_BIT];
  assign mem_busy = xfer_reg == X_BUSY;
  assign run_pend = pend_v_reg && ncc_can_run(pend_op_reg, pend_nw_reg,
                                               nif.busy, mem_busy);
  assign run_new = cmd_wr && !run_pend &&
                   ncc_can_run(new_op, new_nw, nif.busy, mem_busy);
  assign store_new = cmd_wr && !run_new && (!pend_v_reg || run_pend);
  assign exe_v = run_pend || run_new;
  assign exe_op = run_pend ? pend_op_reg : new_op;

  logic do_init;
  logic do_push;
  logic do_log;
  logic do_xfer;
  logic save_done;
  logic init_now;
  assign do_init = exe_v && exe_op == OP_INITIALIZE;
  assign do_push = exe_v && exe_op >= OP_PUSH_ZERO_CONST &&
                   exe_op <= OP_PUSH_LN_TWO;
  assign do_log = exe_v && (exe_op == OP_Y_TIMES_LOG2_X ||
                            exe_op == OP_Y_TIMES_LOG2_X_PLUS_ONE);
  assign do_xfer = exe_v && exe_op >= OP_LOAD_CONTROL_WORD &&
                   exe_op <= OP_RESTORE_STATE && exe_op != OP_CLEAR_EXCEPTIONS;

  // ==========================================================
  // Stack and status decode
  logic [2:0] top_dn;
  logic [2:0] top_up;
  logic push_ok;
  logic log_ok;
  logic stack_fault;
  logic irq_now;
  logic [15:0] sw_word;
  logic [15:0] tag_word;
  ncc_real_t push_val;
  assign top_dn = top_reg - 3'h1;
  assign top_up = top_reg + 3'h1;
  assign push_val = ncc_const(exe_op);
  assign push_ok = tag_reg[top_dn] == NCC_TAG_EMPTY;
  assign log_ok = tag_reg[top_reg] != NCC_TAG_EMPTY &&
                  tag_reg[top_up] != NCC_TAG_EMPTY;
  assign stack_fault = (do_push && !push_ok) || (do_log && !log_ok);
  assign irq_now = !cw_reg[NCC_CW_IEM_BIT] &&
                   |(exc_reg & ~cw_reg[NCC_EXC_W-1:0]);
  assign sw_word = {busy_reg, cc_reg[3], top_reg, cc_reg[2:0], irq_now,
                    1'b0, exc_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_tag
      assign tag_word[2*gi+1:2*gi] = tag_reg[gi];
    end
  endgenerate

  assign nif.start = do_log && log_ok;
  assign nif.abort = init_now;
  assign nif.plus_one = exe_op == OP_Y_TIMES_LOG2_X_PLUS_ONE;
  assign nif.x = fp_reg[top_reg];
  assign nif.y = fp_reg[top_up];

  // ==========================================================
  // Memory transfer sequencing
  logic beat;
  logic single;
  logic last;
  logic xfer_end;
  ncc_op_t kind_nx;
  logic [5:0] idx_nx;
  logic [2:0] part_nx;
  logic [2:0] ri_nx;
  logic [2:0] phys_nx;
  logic [2:0] phys_cur;
  ncc_real_t save_reg_val;
  logic [15:0] part_word;
  logic [15:0] word_nx;
  assign beat = mem_busy && mem_ack;
  assign single = kind_reg != OP_SAVE_STATE && kind_reg != OP_RESTORE_STATE;
  assign last = single ? idx_reg == NCC_IDX_CW : idx_reg == NCC_SAVE_LAST;
  assign xfer_end = beat && last;
  assign save_done = xfer_end && kind_reg == OP_SAVE_STATE;
  assign init_now = do_init || save_done;
  assign kind_nx = do_xfer ? exe_op : kind_reg;
  assign idx_nx = do_xfer ? 6'h0 : idx_reg + 6'h1;
  assign part_nx = (idx_nx <= NCC_ENV_WORDS) ? 3'h0 :
                   (part_reg == NCC_PART_LAST ? 3'h0 : part_reg + 3'h1);
  assign ri_nx = (idx_nx <= NCC_ENV_WORDS) ? 3'h0 :
                 (part_reg == NCC_PART_LAST ? ri_reg + 3'h1 : ri_reg);
  assign phys_nx = top_reg + ri_nx;
  assign phys_cur = top_reg + ri_reg;
  assign save_reg_val = fp_reg[phys_nx];
  assign part_word = save_reg_val[16*part_nx +: 16];
  assign word_nx = (kind_nx == OP_STORE_CONTROL_WORD) ? cw_reg :
                   (kind_nx == OP_STORE_STATUS_WORD) ? sw_word :
                   (idx_nx == NCC_IDX_CW) ? cw_reg :
                   (idx_nx == NCC_IDX_SW) ? sw_word :
                   (idx_nx == NCC_IDX_TAG) ? tag_word :
                   (idx_nx < NCC_ENV_WORDS) ? 16'h0 : part_word;

  always_ff @(posedge clock) begin
    if (srst || init_now) begin
      xfer_reg <= X_IDLE;
      mem_req_reg <= 1'b0;
    end else if (do_xfer || (beat && !last)) begin
      xfer_reg <= X_BUSY;
      mem_req_reg <= 1'b1;
    end else if (xfer_end) begin
      xfer_reg <= X_IDLE;
      mem_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      kind_reg <= OP_STORE_STATUS_WORD;
      idx_reg <= 6'h0;
      part_reg <= 3'h0;
      ri_reg <= 3'h0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_wdata_reg <= 16'h0;
    end else if (do_xfer || (beat && !last)) begin
      kind_reg <= kind_nx;
      idx_reg <= idx_nx;
      part_reg <= part_nx;
      ri_reg <= ri_nx;
      mem_we_reg <= kind_nx != OP_LOAD_CONTROL_WORD &&
                    kind_nx != OP_RESTORE_STATE;
      mem_addr_reg <= base_reg + {13'h0, idx_nx, 1'b0};
      mem_wdata_reg <= word_nx;
    end
  end

  // ==========================================================
  // Architectural state
  always_ff @(posedge clock) begin
    if (srst || init_now) begin
      cw_reg <= NCC_CW_RESET;
      exc_reg <= '0;
      cc_reg <= 4'h0;
      top_reg <= 3'h0;
      busy_reg <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        tag_reg[i] <= NCC_TAG_EMPTY;
      end
    end else begin
      if (exe_v && exe_op == OP_CLEAR_EXCEPTIONS) begin
        exc_reg <= '0;
        busy_reg <= 1'b0;
      end
      if (stack_fault) begin
        exc_reg[NCC_EXC_INVALID_BIT] <= 1'b1;
      end
      if (nif.done) begin
        busy_reg <= 1'b0;
      end
      if (nif.start) begin
        busy_reg <= 1'b1;
      end
      if (exe_v && exe_op == OP_DISABLE_IRQ) begin
        cw_reg[NCC_CW_IEM_BIT] <= 1'b1;
      end
      if (exe_v && exe_op == OP_ENABLE_IRQ) begin
        cw_reg[NCC_CW_IEM_BIT] <= 1'b0;
      end
      if (beat && kind_reg == OP_LOAD_CONTROL_WORD) begin
        cw_reg <= mem_rdata;
      end
      if (do_push && push_ok) begin
        top_reg <= top_dn;
        tag_reg[top_dn] <= (exe_op == OP_PUSH_ZERO_CONST) ? NCC_TAG_ZERO
                                                          : NCC_TAG_VALID;
      end
      if (nif.done) begin
        top_reg <= top_up;
        tag_reg[top_reg] <= NCC_TAG_EMPTY;
        tag_reg[top_up] <= (nif.result[78:64] == 15'h0) ? NCC_TAG_ZERO
                                                        : NCC_TAG_VALID;
      end
      if (beat && kind_reg == OP_RESTORE_STATE) begin
        if (idx_reg == NCC_IDX_CW) begin
          cw_reg <= mem_rdata;
        end else if (idx_reg == NCC_IDX_SW) begin
          exc_reg <= mem_rdata[NCC_EXC_W-1:0];
          cc_reg <= {mem_rdata[NCC_SW_C3_BIT],
                     mem_rdata[NCC_SW_C0_BIT +: 3]};
          top_reg <= mem_rdata[NCC_SW_TOP_LSB +: 3];
        end else if (idx_reg == NCC_IDX_TAG) begin
          for (int i = 0; i < 8; i++) begin
            tag_reg[i] <= mem_rdata[2*i +: 2];
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (do_push && push_ok && !init_now) begin
      fp_reg[top_dn] <= push_val;
    end
    if (nif.done && !init_now) begin
      fp_reg[top_up] <= nif.result;
    end
    if (beat && kind_reg == OP_RESTORE_STATE &&
        idx_reg >= NCC_ENV_WORDS) begin
      fp_reg[phys_cur][16*part_reg +: 16] <= mem_rdata;
    end
  end

  // ==========================================================
  // Host-side registers, queue and pins
  logic [NCC_DW-1:0] rd_mux;
  ncc_real_t top_val;
  assign top_val = fp_reg[top_reg];
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      NCC_REG_CMD: rd_mux = {29'h0, pend_v_reg, mem_busy, nif.busy};
      NCC_REG_STATUS: rd_mux = {16'h0, sw_word};
      NCC_REG_CONTROL: rd_mux = {16'h0, cw_reg};
      NCC_REG_TOP_LO: rd_mux = top_val[31:0];
      NCC_REG_TOP_MID: rd_mux = top_val[63:32];
      NCC_REG_TOP_HI: rd_mux = {16'h0, top_val[79:64]};
      NCC_REG_MEM_BASE: rd_mux = {12'h0, base_reg};
      NCC_REG_TAGS: rd_mux = {16'h0, tag_word};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_reg <= '0;
      base_reg <= '0;
      pend_v_reg <= 1'b0;
      pend_op_reg <= OP_INITIALIZE;
      pend_nw_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : '0;
      irq_reg <= irq_now;
      if (reg_wr && reg_addr == NCC_REG_MEM_BASE) begin
        base_reg <= reg_wdata[NCC_MAW-1:0];
      end
      if (store_new) begin
        pend_v_reg <= 1'b1;
        pend_op_reg <= new_op;
        pend_nw_reg <= new_nw;
      end else if (run_pend) begin
        pend_v_reg <= 1'b0;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign irq = irq_reg;
  assign busy = busy_reg;

endmodule // numeric_coproc_control_ops

// [verification/ncc_sva.sv]
/* Checker on the top ports of the coprocessor control block.
   Assumes one clock and a synchronous active-high reset. */
module ncc_sva (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic mem_ack,
  input wire logic irq,
  input wire logic busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // No-wait command taken while the memory port is quiet
  wire logic nw = reg_wr && reg_addr == 8'h00 && reg_wdata[8] && !mem_req;
  wire logic [4:0] op = reg_wdata[4:0];
  property p_rd; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd)
    else $error("read data outside read slot");
  property p_hold;
    mem_req && !mem_ack |=> !mem_req || $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold)
    else $error("memory request changed before ack");
  property p_step;
    mem_req && mem_ack ##1 mem_req |-> mem_addr == $past(mem_addr) + 20'h2;
  endproperty
  a_step: assert property (p_step)
    else $error("image word address not consecutive");
  property p_clex; nw && op == 5'h0f |-> ##2 !irq && !busy; endproperty
  a_clex: assert property (p_clex)
    else $error("clear left irq or busy");
  property p_disi; nw && op == 5'h0a |-> ##2 !irq; endproperty
  a_disi: assert property (p_disi)
    else $error("irq while disabled");
  property p_init;
    reg_wr && reg_addr == 8'h00 && reg_wdata[8:0] == 9'h109
      |-> ##2 !mem_req ##1 !irq;
  endproperty
  a_init: assert property (p_init)
    else $error("init did not abort");
  property p_store;
    nw && op inside {5'h0d, 5'h0e} |-> ##[1:2] mem_req && mem_we;
  endproperty
  a_store: assert property (p_store)
    else $error("store not started");
  property p_busy; $rose(busy) |-> ##[1:24] !busy; endproperty
  a_busy: assert property (p_busy)
    else $error("busy too long");
  c_save: cover property (mem_req && mem_ack && mem_we);
  c_irq: cover property ($rose(irq));
  c_busy: cover property ($rose(busy));
endmodule // ncc_sva
bind numeric_coproc_control_ops ncc_sva i_sva (.clock, .srst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_req, .mem_we, .mem_addr,
  .mem_ack, .irq, .busy);

// [verification/ncc_mem_model.sv]
/* Memory slave on the block's memory port.
   Assumes the block's clock; slow adds three wait cycles. */
module ncc_mem_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] mem [0:1023];
  logic [1:0] dly = 2'h0;
  int wr_count = 0;
  wire logic [9:0] idx = mem_addr[10:1];
  initial {mem_ack, mem_rdata} = 17'h05a5a;
  // Read data toggles outside the ack cycle
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!srst && mem_req && !mem_ack) begin
      dly <= dly + 2'h1;
      if (!slow || dly == 2'h3) begin
        mem_ack <= 1'b1;
        dly <= 2'h0;
        if (mem_we) begin
          mem[idx] <= mem_wdata;
          wr_count <= wr_count + 1;
        end else begin
          mem_rdata <= mem[idx];
        end
      end
    end
  end
endmodule // ncc_mem_model

// [verification/numeric_coproc_control_ops_test.sv]
/* Bench for the coprocessor control block with a memory model.
   Assumes the register map and opcodes of ncc_pkg. */
module numeric_coproc_control_ops_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ncc_pkg::*;
  logic clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, slow = 0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic mem_req, mem_we, mem_ack, irq, busy;
  logic [19:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  int err_total = 0, compares = 0, n = 0, base = 0;
  ncc_real_t kv [7] = '{NCC_K_ZERO, NCC_K_ONE, NCC_K_PI, NCC_K_LOG2_TEN,
    NCC_K_LOG2_E, NCC_K_LOG10_TWO, NCC_K_LN_TWO};
  numeric_coproc_control_ops i_dut (.clock, .srst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .irq, .busy);
  ncc_mem_model i_mem (.clock, .srst, .slow, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  initial forever #25 clock = ~clock;
  // ==========================================
  // Access tasks
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(logic [7:0] a, string nm, logic [31:0] e,
      logic [31:0] k = 32'hffffffff);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata & k, e);
    @(posedge clock);
  endtask
  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic idle;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((busy !== 1'b0 || mem_req !== 1'b0) && n < 400);
    if (n >= 400) begin
      err_total++;
      stop_test;
    end
    @(posedge clock);
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(8'h08, "reset sw", 32'h0);
    rd(8'h0c, "reset cw", 32'h3ff);
    rd(8'h20, "reset tags", 32'hffff);
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, 32'(i + 2));
      rd(8'h10, "const lo", kv[i][31:0]);
      rd(8'h14, "const mid", kv[i][63:32]);
      rd(8'h18, "const hi", {16'h0, kv[i][79:64]});
      rd(8'h08, "push top", 32'(7 - i) << 11, 32'h3800);
    end
    $display("test constants done");
    wr(8'h1c, 32'h100);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h10a);
    rd(8'h0c, "mask busy", 32'h80, 32'h80);
    rd(8'h08, "neu busy", 32'h8000, 32'h8000);
    idle;
    rd(8'h08, "pop top", 32'h1000, 32'hb800);
    rd(8'h20, "pop tags", 32'hc, 32'h3c);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h10e);
    repeat (2) @(posedge clock);
    wr(8'h00, 32'h10f);
    rd(8'h08, "clex busy", 32'h0, 32'h8000);
    // Busy pin is cleared but the logarithm still runs; let it pop
    repeat (10) @(posedge clock);
    idle;
    chk("stored busy", 32'(i_mem.mem[128][15]), 32'h1);
    rd(8'h08, "pop2 top", 32'h1800, 32'h3800);
    $display("test log done");
    wr(8'h00, 32'h109);
    rd(8'h20, "init tags", 32'hffff);
    wr(8'h00, 32'h0);
    rd(8'h08, "invalid", 32'h1, 32'h3f);
    #1 chk("irq masked", 32'(irq), 32'h0);
    i_mem.mem[128] = 16'h0;
    wr(8'h00, 32'hc);
    idle;
    #1 chk("irq ldcw", 32'(irq), 32'h1);
    wr(8'h00, 32'h10a);
    #1 chk("irq disi", 32'(irq), 32'h0);
    wr(8'h00, 32'h10b);
    #1 chk("irq eni", 32'(irq), 32'h1);
    wr(8'h00, 32'h10f);
    #1 chk("irq clex", 32'(irq), 32'h0);
    wr(8'h00, 32'hc);
    idle;
    #1 chk("irq clean cw", 32'(irq), 32'h0);
    $display("test irq done");
    slow <= 1'b1;
    wr(8'h00, 32'h109);
    wr(8'h00, 32'h3);
    wr(8'h00, 32'h4);
    wr(8'h00, 32'h0);
    base = i_mem.wr_count;
    wr(8'h00, 32'h110);
    for (n = 0; mem_req !== 1'b1 && n < 100; n++) @(negedge clock);
    if (n >= 100) begin
      err_total++;
      stop_test;
    end
    chk("save queued", 32'(busy), 32'h0);
    idle;
    chk("save words", i_mem.wr_count - base, 32'd47);
    chk("image tags", i_mem.mem[130], 32'h3fff);
    rd(8'h20, "save init", 32'hffff);
    i_mem.mem[128] = 16'h0;
    i_mem.mem[129] = i_mem.mem[129] | 16'h1;
    wr(8'h00, 32'h11);
    idle;
    rd(8'h20, "restored tags", 32'h3fff);
    #1 chk("irq restore", 32'(irq), 32'h1);
    base = i_mem.wr_count;
    wr(8'h00, 32'h110);
    wr(8'h00, 32'h109);
    idle;
    chk("save cut", 32'(i_mem.wr_count - base < 47), 32'h1);
    rd(8'h0c, "abort cw", 32'h3ff);
    $display("test save done");
    stop_test;
  end
endmodule // numeric_coproc_control_ops_test
